//--- lin_prepare_and_dynid_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpd_cfg.svh"
module lin_prepare_and_dynid_decoder_test;
   import lpd_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0;        // 100 MHz clock, async reset
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;          // q holds the last read word
   logic        pready, armed, tbl_valid, ids_written, frame_err;
   logic [6:0]  phys_addr = 7'h25, arm_cmd, ans_cmd; // node address
   logic [63:0] ans_data = 64'h8877665544332211;
   logic [3:0]  tbl_ptr = 4'h0;
   logic [5:0]  tbl_id;
   int          mismatches = 0, checks = 0;
   int          writes = 0, errs = 0;               // status pulses seen
   lpd_frame_if lpd_frame_if_i ();
   lpd_mst lpd_mst_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .lnk(lpd_frame_if_i.master));
   lpd_dev lpd_dev_i (.pclk(pclk), .presetn(presetn), .lnk(lpd_frame_if_i.slave), .phys_addr(phys_addr),
      .ans_data(ans_data), .tbl_ptr(tbl_ptr), .armed(armed), .arm_cmd(arm_cmd), .ans_req(), .ans_cmd(ans_cmd),
      .frame_err(frame_err), .ids_written(ids_written), .tbl_id(tbl_id), .tbl_valid(tbl_valid));
   lpd_link_checker lpd_link_checker_i (.pclk(pclk), .presetn(presetn), .m_start(lpd_frame_if_i.m_start),
      .m_id(lpd_frame_if_i.m_id), .m_valid(lpd_frame_if_i.m_valid), .m_data(lpd_frame_if_i.m_data),
      .m_end(lpd_frame_if_i.m_end), .s_valid(lpd_frame_if_i.s_valid), .s_data(lpd_frame_if_i.s_data));
   always #5 pclk = ~pclk;
   // count the device's status pulses; unknown before reset counts as none
   always @(posedge pclk) begin
      if (ids_written === 1'b1) writes++;
      if (frame_err === 1'b1) errs++;
   end
   task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   // one transfer, then an idle cycle so psel never toggles twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic [31:0] args(input logic b, input logic [6:0] a, input logic [6:0] c,
      input logic [5:0] i);
      return {7'h00, b, 1'b0, a, 1'b0, c, 2'b00, i};
   endfunction : args
   // load arguments, start, poll done, clear done; the watchdog bounds the poll
   task automatic frame(input logic [1:0] k, input logic [31:0] ar, input logic [23:0] ids, input logic [15:0] ps);
      apb(1'b1, `LPD_OFS_ARGS, ar);
      apb(1'b1, `LPD_OFS_DYNIDS, {8'h00, ids});
      apb(1'b1, `LPD_OFS_PTRS, {16'h0000, ps});
      apb(1'b1, `LPD_OFS_CTRL, {1'b1, 29'h0, k});
      do apb(1'b0, `LPD_OFS_STATUS, 32'h0); while (q[1] !== 1'b1);
      apb(1'b1, `LPD_OFS_STATUS, 32'h2);
   endtask : frame
   // read-back lags the pointer by a cycle
   task automatic slot(input logic [3:0] p, input logic [5:0] id, input logic v);
      tbl_ptr <= p;
      repeat (2) @(posedge pclk);
      cmp("slot valid", v, tbl_valid);
      if (v) cmp("slot id", id, tbl_id);
   endtask : slot
   // broad bit zero: stored whatever the address field says
   task automatic t_assign_broadcast;
      slot(4'h8, 6'h00, 1'b0);
      frame(K_ASSIGN, args(1'b0, 7'h00, 7'h00, 6'h00), {6'h31, 6'h2b, 6'h05, 6'h1a}, 16'hf328);
      slot(4'h8, 6'h1a, 1'b1);
      slot(4'h2, 6'h05, 1'b1);
      slot(4'h3, 6'h2b, 1'b1);
      slot(4'hf, 6'h31, 1'b1);
      slot(4'h0, 6'h00, 1'b0);
   endtask : t_assign_broadcast
   // broad bit set: foreign address ignored, own address stored, last pair wins
   task automatic t_assign_addressed;
      frame(K_ASSIGN, args(1'b1, 7'h26, 7'h00, 6'h00), {4{6'h22}}, 16'h1111);
      slot(4'h1, 6'h00, 1'b0);
      cmp("assignments stored", 1, writes);
      frame(K_ASSIGN, args(1'b1, 7'h25, 7'h00, 6'h00), {6'h3e, {3{6'h22}}}, 16'h1111);
      slot(4'h1, 6'h3e, 1'b1);
      slot(4'h8, 6'h1a, 1'b1);
   endtask : t_assign_addressed
   // preparing frame, then when armed the reading frame right behind it
   task automatic t_prep_read(input logic [1:0] k, input logic [5:0] id, input logic [6:0] c,
      input logic [6:0] a, input logic arm);
      frame(k, args(1'b0, a, c, id), 24'h0, 16'h0);
      cmp("armed", arm, armed);
      if (arm) begin
         cmp("command", c, arm_cmd);
         cmp("answer command", c, ans_cmd);
         ans_data <= ~ans_data;
         frame(K_READ, args(1'b0, 7'h00, 7'h00, 6'h3d), 24'h0, 16'h0);
         apb(1'b0, `LPD_OFS_RDLO, 32'h0);
         cmp("answer low", ans_data[31:0], q);
         apb(1'b0, `LPD_OFS_RDHI, 32'h0);
         cmp("answer high", ans_data[63:32], q);
         apb(1'b0, `LPD_OFS_STATUS, 32'h0);
         cmp("answer checksum", 1'b1, q[2]);
         cmp("armed after read", 1'b0, armed);
      end
   endtask : t_prep_read
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_assign_broadcast;
      t_assign_addressed;
      t_prep_read(K_PREP_SHORT, 6'h1a, 7'h03, 7'h25, 1'b1);
      t_prep_read(K_PREP_LONG, 6'h3c, 7'h01, 7'h25, 1'b1);
      t_prep_read(K_PREP_LONG, 6'h3c, 7'h02, 7'h26, 1'b0);
      t_prep_read(K_PREP_SHORT, 6'h15, 7'h03, 7'h25, 1'b0);
      t_prep_read(K_PREP_SHORT, 6'h1a, 7'h7f, 7'h25, 1'b1);
      cmp("frame errors", 0, errs);
      complete_run;
   end
   // a hung handshake ends the run as a failure
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      complete_run;
   end
endmodule : lin_prepare_and_dynid_decoder_test
`default_nettype wire

//--- lpd_cfg.svh
`ifndef LPD_CFG_SVH
`define LPD_CFG_SVH
// reserved identifiers, six content bits
`define LPD_ID_CMD      6'h3c
`define LPD_ID_READ     6'h3d
`define LPD_ID_EXT      6'h3f
// data-field codes
`define LPD_MARKER      8'h80
`define LPD_CMD_ASSIGN  7'h11
`define LPD_PTR_PREP    4'h8
`define LPD_FILL        8'hff
// frame lengths in data bytes
`define LPD_NB_LONG     4'h8
`define LPD_NB_ANS      4'h8
// controller register offsets
`define LPD_OFS_CTRL    8'h00
`define LPD_OFS_ARGS    8'h04
`define LPD_OFS_DYNIDS  8'h08
`define LPD_OFS_PTRS    8'h0c
`define LPD_OFS_STATUS  8'h10
`define LPD_OFS_RDLO    8'h14
`define LPD_OFS_RDHI    8'h18
// field positions
`define LPD_CTRL_GO     31
`define LPD_STAT_DONE   1
`endif

//--- lpd_chk_acc.sv
`timescale 1ns/1ns
`default_nettype none
module lpd_chk_acc
   import lpd_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clr,      // restart the sum
   input  wire logic       add,      // fold din into the sum
   input  wire logic [7:0] din,
   output logic      [7:0] sum       // running sum, not yet inverted
);
   logic [7:0] sum_r;  // running sum

   // clear and add in one cycle starts a fresh sum with din
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_r <= 8'h00;
      end else if (clr) begin
         sum_r <= add ? din : 8'h00;
      end else if (add) begin
         sum_r <= lpd_chk_add(sum_r, din);
      end
   end
   assign sum = sum_r;
endmodule : lpd_chk_acc
`default_nettype wire

//--- lpd_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpd_cfg.svh"
module lpd_dev
   import lpd_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   lpd_frame_if.slave       lnk,
   input  wire logic [6:0]  phys_addr,    // this node's physical address
   input  wire logic [63:0] ans_data,     // answer bytes, byte 0 in [7:0]
   input  wire logic [3:0]  tbl_ptr,      // table read-back pointer
   output logic             armed,        // armed for the next reading frame
   output logic      [6:0]  arm_cmd,      // command from the last preparing frame
   output logic             ans_req,      // pulse: present ans_data now
   output logic      [6:0]  ans_cmd,      // command to answer
   output logic             frame_err,    // pulse: bad parity, length or checksum
   output logic             ids_written,  // pulse: assignment frame stored
   output logic      [5:0]  tbl_id,       // identifier held at tbl_ptr
   output logic             tbl_valid     // slot at tbl_ptr has been assigned
);
   localparam int SLOTS = 16;             // one per four-bit pointer value

   lpd_dstate_type state_r;               // frame sequencer
   logic [7:0]     id_r;                  // identifier of current frame
   logic           id_ok_r;               // its parity was right
   logic [3:0]     nb_r;                  // expected data bytes
   logic [3:0]     cnt_r;                 // bytes seen or sent
   logic           chk_ok_r;              // checksum byte matched
   logic [7:0]     buf_r [8];             // received data bytes
   logic           arm_r;                 // preparing frame accepted
   logic [6:0]     cmd_r;                 // its command
   logic [63:0]    ans_r;                 // latched answer
   logic           s_valid_r;
   logic [7:0]     s_data_r;
   logic           err_r;
   logic           wr_r;
   logic [5:0]     slot_id_r [SLOTS];     // identifier table
   logic           slot_val_r [SLOTS];
   logic [5:0]     tbl_id_r;
   logic           tbl_val_r;
   logic [7:0]     acc_sum;
   logic           acc_add;
   logic [7:0]     acc_din;
   logic [5:0]     pr_id [4];             // unpacked assignment pairs
   logic [3:0]     pr_ptr [4];

   // parity check and early classification of the arriving identifier
   logic start_ok;
   logic rd_hit;
   logic [5:0] id6;
   assign start_ok = (lpd_protect(lnk.m_id[5:0]) == lnk.m_id);
   // indirect read answered only when the previous frame armed us
   assign rd_hit = start_ok && (lnk.m_id[5:0] == `LPD_ID_READ) && arm_r;
   assign id6 = id_r[5:0];

   // frame finished cleanly: right length, parity and checksum
   logic fin;
   logic rx_end;
   assign rx_end = (state_r == DS_RX) && lnk.m_end;
   assign fin = rx_end && id_ok_r && (cnt_r == nb_r + 4'h1) && chk_ok_r;

   // the ANS byte being sent this cycle
   logic [7:0] tx_byte;
   assign tx_byte = ans_r[{cnt_r[2:0], 3'b000} +: 8];

   // short preparing frame: identifier must sit in the preparing slot
   logic reserved_id;
   logic short_prep;
   assign reserved_id = (id6 == `LPD_ID_CMD) || (id6 == `LPD_ID_READ) || (id6 == `LPD_ID_EXT);
   assign short_prep = fin && !reserved_id
                    && slot_val_r[`LPD_PTR_PREP] && (slot_id_r[`LPD_PTR_PREP] == id6)
                    && buf_r[0][7] && buf_r[1][7] && (buf_r[1][6:0] == phys_addr);

   // long frames on the command identifier, gated by the marker byte
   logic long_cmd;
   logic assign_f;
   logic long_prep;
   assign long_cmd = fin && (id6 == `LPD_ID_CMD) && (buf_r[0] == `LPD_MARKER) && buf_r[1][7];
   // broadcast bit clear means store regardless of address
   assign assign_f = long_cmd && (buf_r[1][6:0] == `LPD_CMD_ASSIGN)
                  && (!buf_r[2][7] || (buf_r[2][6:0] == phys_addr));
   assign long_prep = long_cmd && (buf_r[1][6:0] != `LPD_CMD_ASSIGN)
                   && buf_r[2][7] && (buf_r[2][6:0] == phys_addr);

   // pair extraction, lsb first within each byte
   always_comb begin
      pr_ptr[0] = buf_r[3][3:0];
      pr_id[0]  = {buf_r[4][1:0], buf_r[3][7:4]};
      pr_ptr[1] = buf_r[4][5:2];
      pr_id[1]  = {buf_r[5][3:0], buf_r[4][7:6]};
      pr_ptr[2] = buf_r[5][7:4];
      pr_id[2]  = buf_r[6][5:0];
      pr_ptr[3] = {buf_r[7][1:0], buf_r[6][7:6]};
      pr_id[3]  = buf_r[7][7:2];
   end

   // sequencer; a new identifier always restarts it, even mid-frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= DS_IDLE;
         id_r    <= 8'h00;
         id_ok_r <= 1'b0;
         nb_r    <= 4'h0;
         cnt_r   <= 4'h0;
      end else if (lnk.m_start) begin
         id_r    <= lnk.m_id;
         id_ok_r <= start_ok;
         nb_r    <= lpd_nbytes(lnk.m_id[5:0]);
         cnt_r   <= 4'h0;
         state_r <= rd_hit ? DS_ANS : DS_RX;
      end else if (lnk.m_end) begin
         state_r <= DS_IDLE;
      end else begin
         unique case (state_r)
            DS_IDLE: state_r <= DS_IDLE;
            DS_RX: begin
               // saturate so an over-long frame cannot wrap to a legal count
               if (lnk.m_valid && cnt_r != 4'hf) begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            DS_ANS:  state_r <= DS_TX;
            DS_TX: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == `LPD_NB_ANS) begin
                  state_r <= DS_DONE;
               end
            end
            DS_DONE: state_r <= DS_DONE;
         endcase
      end
   end

   // data capture and checksum comparison
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) begin
            buf_r[i] <= 8'h00;
         end
         chk_ok_r <= 1'b0;
      end else if (lnk.m_start) begin
         chk_ok_r <= 1'b0;
      end else if (state_r == DS_RX && lnk.m_valid) begin
         if (cnt_r < nb_r) begin
            buf_r[cnt_r[2:0]] <= lnk.m_data;
         end else if (cnt_r == nb_r) begin
            chk_ok_r <= (~acc_sum == lnk.m_data);
         end
      end
   end

   // arming: any new frame disarms, so only the next frame can be answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_r <= 1'b0;
         cmd_r <= 7'h00;
      end else if (lnk.m_start) begin
         arm_r <= 1'b0;
      end else if (short_prep) begin
         arm_r <= 1'b1;
         cmd_r <= buf_r[0][6:0];
      end else if (long_prep) begin
         arm_r <= 1'b1;
         cmd_r <= buf_r[1][6:0];
      end
   end

   // answer: latch user data, then eight bytes and the checksum
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ans_r     <= 64'h0;
         s_valid_r <= 1'b0;
         s_data_r  <= 8'h00;
      end else begin
         s_valid_r <= (state_r == DS_TX) && !lnk.m_start && !lnk.m_end;
         if (state_r == DS_ANS) begin
            ans_r <= ans_data;
         end
         if (state_r == DS_TX) begin
            s_data_r <= (cnt_r < `LPD_NB_ANS) ? tx_byte : ~acc_sum;
         end
      end
   end

   // one accumulator serves receive and transmit, never both at once
   assign acc_add = ((state_r == DS_RX) && lnk.m_valid && (cnt_r < nb_r))
                 || ((state_r == DS_TX) && (cnt_r < `LPD_NB_ANS));
   assign acc_din = (state_r == DS_TX) ? tx_byte : lnk.m_data;

   lpd_chk_acc u_acc (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (lnk.m_start),
      .add     (acc_add),
      .din     (acc_din),
      .sum     (acc_sum)
   );

   // identifier table: each slot watches all four pairs; the later pair wins a tie
   for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            slot_id_r[s]  <= 6'h00;
            slot_val_r[s] <= 1'b0;
         end else if (assign_f) begin
            for (int k = 0; k < 4; k++) begin
               if (pr_ptr[k] == 4'(s)) begin
                  slot_id_r[s]  <= pr_id[k];
                  slot_val_r[s] <= 1'b1;
               end
            end
         end
      end
   end

   // status pulses and table read-back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r     <= 1'b0;
         wr_r      <= 1'b0;
         tbl_id_r  <= 6'h00;
         tbl_val_r <= 1'b0;
      end else begin
         err_r     <= rx_end && !fin;
         wr_r      <= assign_f;
         tbl_id_r  <= slot_id_r[tbl_ptr];
         tbl_val_r <= slot_val_r[tbl_ptr];
      end
   end

   assign lnk.s_valid = s_valid_r;
   assign lnk.s_data  = s_data_r;
   assign armed       = arm_r;
   assign arm_cmd     = cmd_r;
   assign ans_req     = (state_r == DS_ANS);
   assign ans_cmd     = cmd_r;
   assign frame_err   = err_r;
   assign ids_written = wr_r;
   assign tbl_id      = tbl_id_r;
   assign tbl_valid   = tbl_val_r;
endmodule : lpd_dev
`default_nettype wire

//--- lpd_frame_if.sv
`timescale 1ns/1ns
`default_nettype none
// frame-level link: controller owns the m_ group, device owns the s_ group
interface lpd_frame_if;
   logic       m_start;   // pulse, identifier on m_id
   logic [7:0] m_id;      // protected identifier
   logic       m_valid;   // pulse, one data or checksum byte
   logic [7:0] m_data;
   logic       m_end;     // pulse, frame over
   logic       s_valid;   // pulse, one response byte
   logic [7:0] s_data;
   modport master (output m_start, m_id, m_valid, m_data, m_end, input s_valid, s_data);
   modport slave  (input m_start, m_id, m_valid, m_data, m_end, output s_valid, s_data);
endinterface : lpd_frame_if
`default_nettype wire

//--- lpd_link_checker.sv
`timescale 1ns/1ns
`default_nettype none
// watches the frame link; both ends are design code
module lpd_link_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       m_start,
   input wire logic [7:0] m_id,
   input wire logic       m_valid,
   input wire logic [7:0] m_data,
   input wire logic       m_end,
   input wire logic       s_valid,
   input wire logic [7:0] s_data
);
   logic [7:0] sum_r;    // folded sum of all bytes of the frame
   logic [8:0] sum_nxt;  // raw nine-bit sum
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign sum_nxt = {1'b0, sum_r} + {1'b0, (m_valid ? m_data : s_data)};
   // data plus inverted sum always folds to ff, whichever side sent them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sum_r <= 8'h00;
      else if (m_start)
         sum_r <= 8'h00;
      else if (m_valid || s_valid)
         sum_r <= sum_nxt[7:0] + {7'h00, sum_nxt[8]};
   end
   chk_parity_low: assert property (m_start |-> m_id[6] == (m_id[0] ^ m_id[1] ^ m_id[2] ^ m_id[4]))
      else $error("identifier parity bit 6 wrong");
   chk_parity_high: assert property (m_start |-> m_id[7] == ~(m_id[1] ^ m_id[3] ^ m_id[4] ^ m_id[5]))
      else $error("identifier parity bit 7 wrong");
   chk_sum_frame: assert property (m_end |-> sum_r == 8'hff)
      else $error("frame checksum wrong");
   chk_long_count: assert property (m_start && m_id == 8'h3c |=> m_valid [*8] ##1 m_valid ##1 m_end)
      else $error("long frame not eight bytes and checksum");
   chk_short_count: assert property (m_start && !m_id[5] |=> m_valid [*2] ##1 m_valid ##1 m_end)
      else $error("short frame not two bytes and checksum");
   chk_read_silent: assert property (m_start && m_id == 8'h7d |=> !m_valid [*8])
      else $error("controller sent data in a reading frame");
   chk_answer_burst: assert property ($rose(s_valid) |-> s_valid [*8] ##1 s_valid ##1 !s_valid)
      else $error("answer not eight bytes and checksum");
   chk_answer_cause: assert property ($rose(s_valid) |-> $past(m_start, 3) && $past(m_id, 3) == 8'h7d)
      else $error("answer not right after a reading header");
   cover property (m_start && m_id == 8'h3c);
   cover property ($rose(s_valid));
   cover property (m_end && sum_r == 8'hff);
endmodule : lpd_link_checker
`default_nettype wire

//--- lpd_mst.sv
`timescale 1ns/1ns
`default_nettype none
`include "lpd_cfg.svh"
module lpd_mst
   import lpd_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   lpd_frame_if.master      lnk
);
   lpd_mstate_type state_r;
   lpd_kind_type   kind_r;       // kind in flight
   logic [31:0]    args_r;       // id, command, address, broadcast
   logic [23:0]    dynids_r;     // four identifiers, pair k at [6k]
   logic [15:0]    ptrs_r;       // four pointers, pair k at [4k]
   logic           done_r;       // sticky completion
   logic           rd_ok_r;      // answer checksum matched
   logic [63:0]    rd_r;         // answer bytes
   logic [7:0]     buf_r [8];    // outgoing data bytes
   logic [3:0]     nb_r;
   logic [3:0]     idx_r;
   logic [5:0]     id6_r;
   logic           m_start_r;
   logic [7:0]     m_id_r;
   logic           m_valid_r;
   logic [7:0]     m_data_r;
   logic           m_end_r;
   logic [7:0]     acc_sum;
   logic [31:0]    prdata_r;     // read word, held in a flop

   // zero-wait slave: every access completes in its first access cycle
   logic wr_en;
   logic go;
   assign wr_en = psel && penable && pwrite;
   assign go    = wr_en && (paddr == `LPD_OFS_CTRL) && pwdata[`LPD_CTRL_GO] && (state_r == MS_IDLE);
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // read word captured in the setup cycle, so the access phase still needs no wait;
   // status may be one cycle old when it reaches the bus; unmapped offsets read zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0;
      end else if (psel && !penable) begin
         unique case (paddr)
            `LPD_OFS_CTRL:   prdata_r <= {30'h0, kind_r};
            `LPD_OFS_ARGS:   prdata_r <= args_r;
            `LPD_OFS_DYNIDS: prdata_r <= {8'h00, dynids_r};
            `LPD_OFS_PTRS:   prdata_r <= {16'h0000, ptrs_r};
            `LPD_OFS_STATUS: prdata_r <= {29'h0, rd_ok_r, done_r, state_r != MS_IDLE};
            `LPD_OFS_RDLO:   prdata_r <= rd_r[31:0];
            `LPD_OFS_RDHI:   prdata_r <= rd_r[63:32];
            default:         prdata_r <= 32'h0;
         endcase
      end
   end
   assign prdata = prdata_r;

   // argument registers; writes while busy still land but affect the next frame only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         args_r   <= 32'h0;
         dynids_r <= 24'h0;
         ptrs_r   <= 16'h0;
      end else if (wr_en) begin
         if (paddr == `LPD_OFS_ARGS)   args_r   <= pwdata & 32'h017f7f3f;
         if (paddr == `LPD_OFS_DYNIDS) dynids_r <= pwdata[23:0];
         if (paddr == `LPD_OFS_PTRS)   ptrs_r   <= pwdata[15:0];
      end
   end

   // done is sticky; completion wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
      end else if (state_r == MS_END) begin
         done_r <= 1'b1;
      end else if (wr_en && paddr == `LPD_OFS_STATUS && pwdata[`LPD_STAT_DONE]) begin
         done_r <= 1'b0;
      end
   end

   // frame builder and link sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r   <= MS_IDLE;
         kind_r    <= K_ASSIGN;
         nb_r      <= 4'h0;
         idx_r     <= 4'h0;
         id6_r     <= 6'h00;
         rd_r      <= 64'h0;
         rd_ok_r   <= 1'b0;
         m_start_r <= 1'b0;
         m_id_r    <= 8'h00;
         m_valid_r <= 1'b0;
         m_data_r  <= 8'h00;
         m_end_r   <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            buf_r[i] <= 8'h00;
         end
      end else begin
         m_start_r <= 1'b0;
         m_valid_r <= 1'b0;
         m_end_r   <= 1'b0;
         unique case (state_r)
            MS_IDLE: begin
               if (go) begin
                  kind_r  <= lpd_kind_type'(pwdata[1:0]);
                  state_r <= MS_START;
                  nb_r    <= `LPD_NB_LONG;
                  id6_r   <= `LPD_ID_CMD;
                  buf_r[0] <= `LPD_MARKER;
                  buf_r[1] <= {1'b1, args_r[14:8]};
                  buf_r[2] <= {1'b1, args_r[22:16]};
                  for (int i = 3; i < 8; i++) begin
                     buf_r[i] <= `LPD_FILL;
                  end
                  unique case (lpd_kind_type'(pwdata[1:0]))
                     K_ASSIGN: begin
                        buf_r[1] <= {1'b1, `LPD_CMD_ASSIGN};
                        buf_r[2] <= {args_r[24], args_r[22:16]};
                        buf_r[3] <= {dynids_r[3:0], ptrs_r[3:0]};
                        buf_r[4] <= {dynids_r[7:6], ptrs_r[7:4], dynids_r[5:4]};
                        buf_r[5] <= {ptrs_r[11:8], dynids_r[11:8]};
                        buf_r[6] <= {ptrs_r[13:12], dynids_r[17:12]};
                        buf_r[7] <= {dynids_r[23:18], ptrs_r[15:14]};
                     end
                     K_PREP_SHORT: begin
                        id6_r    <= args_r[5:0];
                        nb_r     <= lpd_nbytes(args_r[5:0]);
                        buf_r[0] <= {1'b1, args_r[14:8]};
                        buf_r[1] <= {1'b1, args_r[22:16]};
                     end
                     K_PREP_LONG: nb_r <= `LPD_NB_LONG;
                     K_READ:      id6_r <= args_r[5:0];
                  endcase
               end
            end
            MS_START: begin
               m_start_r <= 1'b1;
               m_id_r    <= lpd_protect(id6_r);
               idx_r     <= 4'h0;
               state_r   <= (kind_r == K_READ) ? MS_WAIT : MS_DATA;
               if (kind_r == K_READ) begin
                  rd_ok_r <= 1'b0;
               end
            end
            MS_DATA: begin
               m_valid_r <= 1'b1;
               m_data_r  <= buf_r[idx_r[2:0]];
               idx_r     <= idx_r + 4'h1;
               if (idx_r == nb_r - 4'h1) begin
                  state_r <= MS_CHK;
               end
            end
            MS_CHK: begin
               m_valid_r <= 1'b1;
               m_data_r  <= ~acc_sum;
               state_r   <= MS_END;
            end
            MS_WAIT: begin
               if (lnk.s_valid) begin
                  idx_r <= idx_r + 4'h1;
                  if (idx_r < `LPD_NB_ANS) begin
                     rd_r[{idx_r[2:0], 3'b000} +: 8] <= lnk.s_data;
                  end else begin
                     rd_ok_r <= (~acc_sum == lnk.s_data);
                     state_r <= MS_END;
                  end
               end
            end
            MS_END: begin
               m_end_r <= 1'b1;
               state_r <= MS_IDLE;
            end
         endcase
      end
   end

   lpd_chk_acc u_acc (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (state_r == MS_START),
      .add     ((state_r == MS_DATA) || ((state_r == MS_WAIT) && lnk.s_valid && (idx_r < `LPD_NB_ANS))),
      .din     ((state_r == MS_DATA) ? buf_r[idx_r[2:0]] : lnk.s_data),
      .sum     (acc_sum)
   );

   assign lnk.m_start = m_start_r;
   assign lnk.m_id    = m_id_r;
   assign lnk.m_valid = m_valid_r;
   assign lnk.m_data  = m_data_r;
   assign lnk.m_end   = m_end_r;
endmodule : lpd_mst
`default_nettype wire

//--- lpd_pkg.sv
`include "lpd_cfg.svh"
`default_nettype none
package lpd_pkg;
   // frames the controller can issue
   typedef enum logic [1:0] {K_ASSIGN, K_PREP_SHORT, K_PREP_LONG, K_READ} lpd_kind_type;
   // device end states
   typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ANS, DS_TX, DS_DONE} lpd_dstate_type;
   // controller end states
   typedef enum logic [2:0] {MS_IDLE, MS_START, MS_DATA, MS_CHK, MS_WAIT, MS_END} lpd_mstate_type;

   // six content bits plus the two parity bits
   function automatic logic [7:0] lpd_protect(input logic [5:0] i);
      return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
   endfunction : lpd_protect

   // eight-bit add with the carry folded back in
   function automatic logic [7:0] lpd_chk_add(input logic [7:0] s, input logic [7:0] b);
      logic [8:0] t;
      t = {1'b0, s} + {1'b0, b};
      return t[7:0] + {7'h00, t[8]};
   endfunction : lpd_chk_add

   // data length from identifier bits 5 and 4
   function automatic logic [3:0] lpd_nbytes(input logic [5:0] i);
      unique case (i[5:4])
         2'b10:   return 4'h4;
         2'b11:   return 4'h8;
         default: return 4'h2;
      endcase
   endfunction : lpd_nbytes
endpackage : lpd_pkg
`default_nettype wire
